// ### tb/tb_power_domain_fault_status_bank.sv
/*
 * Self-checking bench of the power domain fault status bank: register
 * reads and writes, summary counts and first-interface capture, masks.
 * Assumes the design files and pd_fault_defines.svh are compiled first.
 */
`timescale 1ns/1ps
`include "pd_fault_defines.svh"

module tb_power_domain_fault_status_bank
    import pd_fault_pkg::*;
;
    localparam int          N_IF        = 4;
    localparam int          CLK_DOMAINS = 2;
    localparam logic [63:0] CLK_PTRS    = 64'h0000_3000_0000_2000;
    localparam logic [31:0] IF_IDENT    = 32'h4433_2211;
    localparam logic [3:0]  IF_ROLE     = 4'ha;
    localparam int          CEILING     = 4000;

    logic                   mclk;
    logic                   rst;
    logic                   ce;
    logic [11:0]            reg_addr;
    logic [31:0]            wr_data;
    logic                   wr_strobe;
    logic                   rd_strobe;
    logic                   reg_secure;
    logic [N_IF-1:0]        irq [0:4];
    logic [31:0]            rd_data;
    logic [31:0]            rd_data_nm;
    logic [4:0]             domain_irq;
    logic [4:0]             domain_irq_nm;
    int                     mismatches;
    int                     samples_checked;
    int                     cycles;

    // ********************************************
    // Two builds: with and without monitoring
    // ********************************************
    power_domain_fault_status_bank #(.N_IF(N_IF), .CLK_DOMAINS(CLK_DOMAINS),
        .CLK_PTRS(CLK_PTRS), .IF_IDENT(IF_IDENT), .IF_ROLE(IF_ROLE),
        .MONITOR_PRESENT(1'b1)) u_dut (
        .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .reg_secure(reg_secure),
        .endpoint_irq(irq[0]), .monitor_irq(irq[1]), .stall_irq(irq[2]),
        .held_irq(irq[3]), .isolation_irq(irq[4]), .rd_data(rd_data),
        .domain_irq(domain_irq));

    power_domain_fault_status_bank #(.N_IF(N_IF), .CLK_DOMAINS(CLK_DOMAINS),
        .CLK_PTRS(CLK_PTRS), .IF_IDENT(IF_IDENT), .IF_ROLE(IF_ROLE),
        .MONITOR_PRESENT(1'b0)) u_nomon (
        .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .wr_data(wr_data),
        .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .reg_secure(reg_secure),
        .endpoint_irq(irq[0]), .monitor_irq(irq[1]), .stall_irq(irq[2]),
        .held_irq(irq[3]), .isolation_irq(irq[4]), .rd_data(rd_data_nm),
        .domain_irq(domain_irq_nm));

    // ********************************************
    // Clock and hang guard
    // ********************************************
    always #25 mclk = ~mclk;

    always @(posedge mclk) begin
        cycles++;
        if (cycles == CEILING) begin
            mismatches++;
            stop_test();
        end
    end

    // ********************************************
    // Tasks
    // ********************************************
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(logic [11:0] a, logic [31:0] dat, logic s);
        @(posedge mclk);
        reg_addr   <= a;
        wr_data    <= dat;
        reg_secure <= s;
        wr_strobe  <= 1'b1;
        @(posedge mclk);
        wr_strobe  <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(logic [11:0] a, logic s, output logic [31:0] d,
                          output logic [31:0] dn);
        @(posedge mclk);
        reg_addr   <= a;
        reg_secure <= s;
        rd_strobe  <= 1'b1;
        @(posedge mclk);
        rd_strobe  <= 1'b0;
        #1;
        d  = rd_data;
        dn = rd_data_nm;
    endtask

    // Secure write, then a read of the same place in the very next cycle
    task automatic reg_wr_rd(logic [11:0] a, logic [31:0] dat, output logic [31:0] d,
                             output logic [31:0] dn);
        @(posedge mclk);
        reg_addr   <= a;
        wr_data    <= dat;
        reg_secure <= 1'b1;
        wr_strobe  <= 1'b1;
        @(posedge mclk);
        wr_strobe  <= 1'b0;
        rd_strobe  <= 1'b1;
        @(posedge mclk);
        rd_strobe  <= 1'b0;
        #1;
        d  = rd_data;
        dn = rd_data_nm;
    endtask

    task automatic set_irq(int c, logic [N_IF-1:0] v);
        @(posedge mclk);
        irq[c] <= v;
    endtask

    function automatic logic [31:0] summ(logic [8:0] n, logic r, logic [7:0] id);
        return {7'h00, n, 7'h00, r, id};
    endfunction

    function automatic logic [11:0] sofs(int c);
        return 12'(`PDF_EP_STATUS_OFS + 8 * c);
    endfunction

    // Reads one summary and the interrupt outputs of both builds
    task automatic check_cat(int c, logic [31:0] e, logic en);
        logic [31:0] d;
        logic [31:0] dn;
        reg_rd(sofs(c), 1'b1, d, dn);
        chk(d, e);
        chk(dn, (c == 0) ? e : 32'h0000_0000);
        chk(32'(domain_irq[c]), 32'(en));
        chk(32'(domain_irq_nm[c]), (c == 0) ? 32'(en) : 32'h0000_0000);
    endtask

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        logic [31:0] d;
        logic [31:0] dn;
        mclk = 1'b0; rst = 1'b1; ce = 1'b1; reg_addr = 12'h000; wr_data = 32'h0;
        wr_strobe = 1'b0; rd_strobe = 1'b0; reg_secure = 1'b0;
        mismatches = 0; samples_checked = 0; cycles = 0;
        for (int c = 0; c < 5; c++) irq[c] = 4'h0;
        repeat (8) @(posedge mclk);
        rst <= 1'b0;

        // Reset values of summaries and masks
        for (int c = 0; c < 5; c++) begin
            reg_rd(sofs(c), 1'b1, d, dn);
            chk(d, 32'h0000_0000);
            reg_rd(sofs(c) + 12'h004, 1'b1, d, dn);
            chk(d, 32'h0000_0000);
        end

        // Geometry words, pointer past the last domain, unmapped place
        reg_rd(`PDF_CHILD_INFO_OFS, 1'b0, d, dn);
        chk(d, 32'(CLK_DOMAINS));
        reg_rd(12'h008, 1'b0, d, dn);
        chk(d, CLK_PTRS[31:0]);
        reg_rd(12'h00c, 1'b0, d, dn);
        chk(d, CLK_PTRS[63:32]);
        reg_rd(12'h010, 1'b0, d, dn);
        chk(d, 32'h0000_0000);
        reg_rd(12'ha00, 1'b1, d, dn);
        chk(d, 32'h0000_0000);

        for (int c = 0; c < 5; c++) begin
            // Late second raiser must not displace the first
            set_irq(c, 4'b1000);
            check_cat(c, summ(9'h001, 1'b1, 8'h44), 1'b1);
            set_irq(c, 4'b1010);
            check_cat(c, summ(9'h002, 1'b1, 8'h44), 1'b1);
            set_irq(c, 4'b0010);
            check_cat(c, summ(9'h001, 1'b1, 8'h44), 1'b1);
            set_irq(c, 4'b0000);
            check_cat(c, summ(9'h000, 1'b1, 8'h44), 1'b0);
            set_irq(c, 4'b0101);
            check_cat(c, summ(9'h002, 1'b0, 8'h11), 1'b1);
            // Mask with reserved bits zero and read back at once, then a non-secure clear
            reg_wr_rd(sofs(c) + 12'h004, 32'h0000_0001, d, dn);
            chk(d, 32'h0000_0001);
            chk(dn, (c == 0) ? 32'h0000_0001 : 32'h0000_0000);
            chk(32'(domain_irq[c]), 32'h0000_0000);
            reg_wr(sofs(c) + 12'h004, 32'h0000_0000, 1'b0);
            reg_rd(sofs(c) + 12'h004, 1'b1, d, dn);
            chk(d, 32'h0000_0001);
            reg_rd(sofs(c), 1'b0, d, dn);
            chk(d, 32'h0000_0000);
            reg_wr(sofs(c) + 12'h004, 32'h0000_0000, 1'b1);
            check_cat(c, summ(9'h002, 1'b0, 8'h11), 1'b1);
            set_irq(c, 4'b0000);
        end

        // Clock enable low freezes the trackers
        @(posedge mclk);
        ce     <= 1'b0;
        irq[0] <= 4'b0001;
        repeat (3) @(posedge mclk);
        #1;
        chk(32'(domain_irq[0]), 32'h0000_0000);
        @(posedge mclk);
        ce <= 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk(32'(domain_irq[0]), 32'h0000_0001);
        set_irq(0, 4'b0000);

        // Mid-run reset clears a mask
        reg_wr(`PDF_STL_MASK_OFS, 32'h0000_0001, 1'b1);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        reg_rd(`PDF_STL_MASK_OFS, 1'b1, d, dn);
        chk(d, 32'h0000_0000);
        stop_test();
    end

endmodule // tb_power_domain_fault_status_bank

// ### verilog/fault_category_tracker.sv
/*
 * One interrupt category: counts the interfaces raising it and keeps the
 * ident and role of the first one.
 * Assumes the interrupt lines are levels from logic on mclk.
 */
`timescale 1ns/1ps
`include "pd_fault_defines.svh"

module fault_category_tracker
    import pd_fault_pkg::*;
#(
    parameter int                    N_IF     = 16,
    parameter logic [N_IF*8-1:0]     IF_IDENT = '0,
    parameter logic [N_IF-1:0]       IF_ROLE  = '0
) (
    input  wire logic                    mclk,
    input  wire logic                    rst,
    input  wire logic                    ce,
    input  wire logic [N_IF-1:0]         irq_lines,
    output logic      [`PDF_COUNT_W-1:0] count,
    output logic                         first_role,
    output logic      [`PDF_IDENT_W-1:0] first_ident
);

    tracker_s st;
    tracker_s next_st;

    always_comb begin
        logic [`PDF_COUNT_W-1:0] tally;
        logic                    found;
        logic                    pick_role;
        logic [`PDF_IDENT_W-1:0] pick_ident;
        tally      = `PDF_COUNT_ZERO;
        found      = 1'b0;
        pick_role  = 1'b0;
        pick_ident = '0;
        next_st    = st;
        // Lowest index wins when several rise in the same cycle
        for (int i = 0; i < N_IF; i++) begin
            if (irq_lines[i]) begin
                tally = tally + `PDF_COUNT_ONE;
                if (!found) begin
                    found      = 1'b1;
                    pick_role  = IF_ROLE[i];
                    pick_ident = IF_IDENT[i*`PDF_IDENT_W +: `PDF_IDENT_W];
                end
            end
        end
        next_st.count = tally;
        if (tally == `PDF_COUNT_ZERO) begin
            next_st.held = 1'b0;
        end else if (!st.held) begin
            next_st.held  = 1'b1;
            next_st.role  = pick_role;
            next_st.ident = pick_ident;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign count       = st.count;
    assign first_role  = st.role;
    assign first_ident = st.ident;

    a_count_tracks: assert property (@(posedge mclk) disable iff (rst)
        ce |=> count == `PDF_COUNT_W'($countones($past(irq_lines))))
        else $error("count does not follow raised lines");

    a_ident_held: assert property (@(posedge mclk) disable iff (rst)
        (ce && st.held && irq_lines != '0) |=> $stable(first_ident) && $stable(first_role))
        else $error("first ident changed while count nonzero");

endmodule // fault_category_tracker

// ### verilog/pd_fault_defines.svh
/*
 * Constants of the power domain fault status bank: register byte offsets,
 * field positions, widths and reset values.
 * Assumes a 12-bit byte address into one 4KB power domain region.
 */
`ifndef PD_FAULT_DEFINES_SVH
`define PD_FAULT_DEFINES_SVH

// ********************************************
// Bus geometry
// ********************************************
`define PDF_ADDR_W          12
`define PDF_DATA_W          32
`define PDF_WORD_SHIFT      2

// ********************************************
// Register byte offsets
// ********************************************
`define PDF_CHILD_INFO_OFS  12'h004
`define PDF_PTR_FIRST_OFS   12'h008
`define PDF_PTR_LAST_OFS    12'h8fc
`define PDF_EP_STATUS_OFS   12'h900
`define PDF_EP_MASK_OFS     12'h904
`define PDF_MON_STATUS_OFS  12'h908
`define PDF_MON_MASK_OFS    12'h90c
`define PDF_STL_STATUS_OFS  12'h910
`define PDF_STL_MASK_OFS    12'h914
`define PDF_HLD_STATUS_OFS  12'h918
`define PDF_HLD_MASK_OFS    12'h91c
`define PDF_ISO_STATUS_OFS  12'h920
`define PDF_ISO_MASK_OFS    12'h924

// ********************************************
// Fields
// ********************************************
`define PDF_COUNT_W         9
`define PDF_COUNT_LSB       16
`define PDF_ROLE_BIT        8
`define PDF_IDENT_W         8
`define PDF_IDENT_LSB       0
`define PDF_MASK_BIT        0
`define PDF_CAT_NUM         5
`define PDF_COUNT_ONE       9'h001
`define PDF_COUNT_ZERO      9'h000
`define PDF_WORD_ZERO       32'h0000_0000
`define PDF_MASK_RESET      5'h00

`endif

// ### verilog/pd_fault_pkg.sv
/*
 * Types shared by the fault status bank and its category tracker.
 * Assumes pd_fault_defines.svh is on the include path.
 */
`include "pd_fault_defines.svh"

package pd_fault_pkg;

    typedef enum logic [2:0] {
        cat_endpoint,
        cat_monitor,
        cat_stall,
        cat_held,
        cat_isolation
    } fault_cat_e;

    typedef struct packed {
        logic [`PDF_COUNT_W-1:0] count;
        logic                    held;
        logic                    role;
        logic [`PDF_IDENT_W-1:0] ident;
    } tracker_s;

    typedef struct packed {
        logic [`PDF_DATA_W-1:0]  rd_data;
        logic [`PDF_CAT_NUM-1:0] mask;
        logic [`PDF_CAT_NUM-1:0] domain_irq;
    } bank_s;

endpackage

// ### verilog/power_domain_fault_status_bank.sv
/*
 * Register bank of one power domain: clock domain count and region
 * pointers, plus count/role/ident summaries and masks for five interrupt
 * categories raised by the interfaces of the domain.
 * Assumes a plain same-clock register port with read data one cycle late,
 * a Secure qualifier beside each access, and interrupt levels on mclk.
 */
`timescale 1ns/1ps
`include "pd_fault_defines.svh"

module power_domain_fault_status_bank
    import pd_fault_pkg::*;
#(
    parameter int                        N_IF            = 16,
    parameter int                        CLK_DOMAINS     = 1,
    parameter logic [CLK_DOMAINS*32-1:0] CLK_PTRS        = '0,
    parameter logic [N_IF*8-1:0]         IF_IDENT        = '0,
    parameter logic [N_IF-1:0]           IF_ROLE         = '0,
    parameter bit                        MONITOR_PRESENT = 1'b1
) (
    input  wire logic                   mclk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    input  wire logic [`PDF_ADDR_W-1:0] reg_addr,
    input  wire logic [`PDF_DATA_W-1:0] wr_data,
    input  wire logic                   wr_strobe,
    input  wire logic                   rd_strobe,
    input  wire logic                   reg_secure,
    input  wire logic [N_IF-1:0]        endpoint_irq,
    input  wire logic [N_IF-1:0]        monitor_irq,
    input  wire logic [N_IF-1:0]        stall_irq,
    input  wire logic [N_IF-1:0]        held_irq,
    input  wire logic [N_IF-1:0]        isolation_irq,
    output logic      [`PDF_DATA_W-1:0] rd_data,
    output logic [`PDF_CAT_NUM-1:0]     domain_irq
);

    // ********************************************
    // Category trackers
    // ********************************************
    logic [N_IF-1:0]         cat_lines [`PDF_CAT_NUM];
    logic [`PDF_COUNT_W-1:0] cat_count [`PDF_CAT_NUM];
    logic                    cat_role  [`PDF_CAT_NUM];
    logic [`PDF_IDENT_W-1:0] cat_ident [`PDF_CAT_NUM];

    always_comb begin
        cat_lines[cat_endpoint]  = endpoint_irq;
        cat_lines[cat_monitor]   = monitor_irq;
        cat_lines[cat_stall]     = stall_irq;
        cat_lines[cat_held]      = held_irq;
        cat_lines[cat_isolation] = isolation_irq;
    end

    genvar c;
    generate
        for (c = 0; c < `PDF_CAT_NUM; c++) begin : g_cat
            fault_category_tracker #(
                .N_IF     (N_IF),
                .IF_IDENT (IF_IDENT),
                .IF_ROLE  (IF_ROLE)
            ) u_tracker (
                .mclk        (mclk),
                .rst         (rst),
                .ce          (ce),
                .irq_lines   (cat_lines[c]),
                .count       (cat_count[c]),
                .first_role  (cat_role[c]),
                .first_ident (cat_ident[c])
            );
        end
    endgenerate

    // ********************************************
    // Helpers
    // ********************************************
    // Reserved bits are built as zero so a read never shows stale wiring
    function automatic logic [`PDF_DATA_W-1:0] summary_word(
        input logic [`PDF_COUNT_W-1:0] cnt,
        input logic                    role,
        input logic [`PDF_IDENT_W-1:0] ident
    );
        logic [`PDF_DATA_W-1:0] w;
        w = `PDF_WORD_ZERO;
        w[`PDF_COUNT_LSB +: `PDF_COUNT_W] = cnt;
        w[`PDF_ROLE_BIT]                  = role;
        w[`PDF_IDENT_LSB +: `PDF_IDENT_W] = ident;
        return w;
    endfunction

    // Maps a summary or mask offset to its category; ok is low elsewhere
    function automatic void decode_cat(
        input  logic [`PDF_ADDR_W-1:0] a,
        output logic                   ok,
        output logic                   is_mask,
        output fault_cat_e             cat
    );
        ok      = 1'b1;
        is_mask = 1'b0;
        cat     = cat_endpoint;
        unique case (a)
            `PDF_EP_STATUS_OFS:  cat = cat_endpoint;
            `PDF_EP_MASK_OFS: begin
                cat     = cat_endpoint;
                is_mask = 1'b1;
            end
            `PDF_MON_STATUS_OFS: cat = cat_monitor;
            `PDF_MON_MASK_OFS: begin
                cat     = cat_monitor;
                is_mask = 1'b1;
            end
            `PDF_STL_STATUS_OFS: cat = cat_stall;
            `PDF_STL_MASK_OFS: begin
                cat     = cat_stall;
                is_mask = 1'b1;
            end
            `PDF_HLD_STATUS_OFS: cat = cat_held;
            `PDF_HLD_MASK_OFS: begin
                cat     = cat_held;
                is_mask = 1'b1;
            end
            `PDF_ISO_STATUS_OFS: cat = cat_isolation;
            `PDF_ISO_MASK_OFS: begin
                cat     = cat_isolation;
                is_mask = 1'b1;
            end
            default:             ok = 1'b0;
        endcase
    endfunction

    // ********************************************
    // Register state
    // ********************************************
    bank_s st;
    bank_s next_st;

    logic [`PDF_ADDR_W-1:0] ptr_index;
    assign ptr_index = (reg_addr - `PDF_PTR_FIRST_OFS) >> `PDF_WORD_SHIFT;

    always_comb begin
        logic       hit;
        logic       is_mask;
        logic       reachable;
        fault_cat_e cat;
        hit       = 1'b0;
        is_mask   = 1'b0;
        reachable = 1'b0;
        cat       = cat_endpoint;
        next_st   = st;
        decode_cat(reg_addr, hit, is_mask, cat);
        // Only the endpoint category exists without monitoring
        reachable = hit && reg_secure
                    && (MONITOR_PRESENT || cat == cat_endpoint);

        // Read data stand one cycle only; unmapped and refused read zero
        next_st.rd_data = `PDF_WORD_ZERO;
        if (rd_strobe) begin
            if (reg_addr == `PDF_CHILD_INFO_OFS) begin
                next_st.rd_data = `PDF_DATA_W'(CLK_DOMAINS);
            end else if (reg_addr >= `PDF_PTR_FIRST_OFS
                         && reg_addr <= `PDF_PTR_LAST_OFS) begin
                if (32'(ptr_index) < CLK_DOMAINS) begin
                    next_st.rd_data = CLK_PTRS[32'(ptr_index)*32 +: 32];
                end
            end else if (reachable && is_mask) begin
                next_st.rd_data[`PDF_MASK_BIT] = st.mask[cat];
            end else if (reachable) begin
                next_st.rd_data = summary_word(cat_count[cat],
                                               cat_role[cat],
                                               cat_ident[cat]);
            end
        end

        // Reserved write bits are dropped, only bit 0 is kept
        if (wr_strobe && reachable && is_mask) begin
            next_st.mask[cat] = wr_data[`PDF_MASK_BIT];
        end

        // Per category line: raised while any interface asserts, unmasked, and the category is present (endpoint only without monitoring)
        for (int k = 0; k < `PDF_CAT_NUM; k++) begin
            next_st.domain_irq[k] = (cat_count[k] != `PDF_COUNT_ZERO)
                                    && !st.mask[k]
                                    && (MONITOR_PRESENT || k == int'(cat_endpoint));
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st.rd_data    <= `PDF_WORD_ZERO;
            st.mask       <= `PDF_MASK_RESET;
            st.domain_irq <= `PDF_MASK_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign rd_data    = st.rd_data;
    assign domain_irq = st.domain_irq;

    // ********************************************
    // Checks
    // ********************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_read_ep;
        ce && rd_strobe && reg_secure && reg_addr == `PDF_EP_STATUS_OFS;
    endsequence

    sequence s_write_ep_mask;
        ce && wr_strobe && reg_secure && reg_addr == `PDF_EP_MASK_OFS;
    endsequence

    sequence s_read_child;
        ce && rd_strobe && reg_addr == `PDF_CHILD_INFO_OFS;
    endsequence

    a_child_count: assert property (s_read_child |=>
        rd_data == `PDF_DATA_W'(CLK_DOMAINS))
        else $error("child count read wrong");

    a_first_ptr: assert property (
        (ce && rd_strobe && reg_addr == `PDF_PTR_FIRST_OFS) |=>
        rd_data == CLK_PTRS[31:0])
        else $error("first pointer read wrong");

    a_ep_count: assert property (s_read_ep |=>
        rd_data[`PDF_COUNT_LSB +: `PDF_COUNT_W] == $past(cat_count[cat_endpoint]))
        else $error("endpoint count read wrong");

    a_ep_role_ident: assert property (s_read_ep |=>
        rd_data[`PDF_ROLE_BIT] == $past(cat_role[cat_endpoint])
        && rd_data[`PDF_IDENT_LSB +: `PDF_IDENT_W] == $past(cat_ident[cat_endpoint]))
        else $error("endpoint role or ident read wrong");

    a_mask_store: assert property (s_write_ep_mask ##1 (ce && rd_strobe && reg_secure
        && reg_addr == `PDF_EP_MASK_OFS) |=>
        rd_data[`PDF_MASK_BIT] == $past(wr_data[`PDF_MASK_BIT], 2))
        else $error("endpoint mask not stored");

    a_masked_silent: assert property (
        (ce && st.mask[cat_endpoint]) |=> !domain_irq[cat_endpoint])
        else $error("masked category still raised");

    a_nonsecure_blind: assert property (
        (ce && rd_strobe && !reg_secure && reg_addr >= `PDF_EP_STATUS_OFS
         && reg_addr <= `PDF_ISO_MASK_OFS) |=> rd_data == `PDF_WORD_ZERO)
        else $error("Non-secure read reached a Secure register");

    a_absent_monitor: assert property (
        (!MONITOR_PRESENT && ce && rd_strobe && reg_addr == `PDF_STL_STATUS_OFS)
        |=> rd_data == `PDF_WORD_ZERO)
        else $error("absent register answered");

    a_rdata_one_cycle: assert property (
        (ce && !rd_strobe) |=> rd_data == `PDF_WORD_ZERO)
        else $error("read data outlived its cycle");

    // ********************************************
    // Checks on the monitoring categories, then reserved bits, pointers, masks and freezing
    // ********************************************
    sequence s_read_mon;
        ce && rd_strobe && reg_secure && MONITOR_PRESENT
        && reg_addr == `PDF_MON_STATUS_OFS;
    endsequence

    sequence s_read_stall;
        ce && rd_strobe && reg_secure && MONITOR_PRESENT
        && reg_addr == `PDF_STL_STATUS_OFS;
    endsequence

    sequence s_read_held;
        ce && rd_strobe && reg_secure && MONITOR_PRESENT
        && reg_addr == `PDF_HLD_STATUS_OFS;
    endsequence

    sequence s_read_iso;
        ce && rd_strobe && reg_secure && MONITOR_PRESENT
        && reg_addr == `PDF_ISO_STATUS_OFS;
    endsequence

    a_mon_summary: assert property (s_read_mon |=>
        rd_data[`PDF_COUNT_LSB +: `PDF_COUNT_W] == $past(cat_count[cat_monitor])
        && rd_data[`PDF_ROLE_BIT] == $past(cat_role[cat_monitor])
        && rd_data[`PDF_IDENT_LSB +: `PDF_IDENT_W] == $past(cat_ident[cat_monitor]))
        else $error("monitor summary read wrong");

    a_stall_summary: assert property (s_read_stall |=>
        rd_data[`PDF_COUNT_LSB +: `PDF_COUNT_W] == $past(cat_count[cat_stall])
        && rd_data[`PDF_ROLE_BIT] == $past(cat_role[cat_stall])
        && rd_data[`PDF_IDENT_LSB +: `PDF_IDENT_W] == $past(cat_ident[cat_stall]))
        else $error("stall summary read wrong");

    a_held_summary: assert property (s_read_held |=>
        rd_data[`PDF_COUNT_LSB +: `PDF_COUNT_W] == $past(cat_count[cat_held])
        && rd_data[`PDF_ROLE_BIT] == $past(cat_role[cat_held])
        && rd_data[`PDF_IDENT_LSB +: `PDF_IDENT_W] == $past(cat_ident[cat_held]))
        else $error("held state summary read wrong");

    a_iso_summary: assert property (s_read_iso |=>
        rd_data[`PDF_COUNT_LSB +: `PDF_COUNT_W] == $past(cat_count[cat_isolation])
        && rd_data[`PDF_ROLE_BIT] == $past(cat_role[cat_isolation])
        && rd_data[`PDF_IDENT_LSB +: `PDF_IDENT_W] == $past(cat_ident[cat_isolation]))
        else $error("isolation summary read wrong");

    a_reserved_zero: assert property (
        (ce && rd_strobe && reg_addr >= `PDF_EP_STATUS_OFS && reg_addr <= `PDF_ISO_MASK_OFS)
        |=> rd_data[`PDF_DATA_W-1:`PDF_COUNT_LSB+`PDF_COUNT_W] == '0
            && rd_data[`PDF_COUNT_LSB-1:`PDF_ROLE_BIT+1] == '0)
        else $error("reserved summary bits not zero");

    a_ptr_beyond: assert property (
        (ce && rd_strobe && reg_addr == `PDF_PTR_FIRST_OFS
         + (`PDF_ADDR_W'(CLK_DOMAINS) << `PDF_WORD_SHIFT)) |=> rd_data == `PDF_WORD_ZERO)
        else $error("pointer past the last clock domain answered");

    a_mask_hold: assert property (
        (ce && !(wr_strobe && reg_secure)) |=> $stable(st.mask))
        else $error("mask changed without a Secure write");

    // Masks act on the registered line, so a mask write hides it one edge later
    a_masks_quiet: assert property (
        ce |=> (domain_irq & $past(st.mask)) == '0)
        else $error("a masked category line is raised");

    a_unmasked_raise: assert property (
        (ce && cat_count[cat_endpoint] != `PDF_COUNT_ZERO && !st.mask[cat_endpoint])
        |=> domain_irq[cat_endpoint])
        else $error("unmasked endpoint line not raised");

    a_absent_quiet: assert property (
        !MONITOR_PRESENT |-> (domain_irq >> cat_monitor) == '0
                             && (st.mask >> cat_monitor) == '0)
        else $error("absent category raised or masked");

    // Frozen outputs let a stalled bank be read later without loss
    a_ce_freeze: assert property (
        !ce |=> $stable(rd_data) && $stable(domain_irq))
        else $error("outputs moved while clock enable low");

endmodule // power_domain_fault_status_bank
